// [char_sync_drop_framer.sv]
`timescale 1ns/100ps
// What this block does
// RULE1 - All-ones frame is flagged as line idle. Code tests the stored form: ignore mode with 5- to 7-bit codes never flags it.
// RULE2 - Drop processing only in synchronous character mode.
// RULE3 - Seven drop characters, entry one within-text.
// RULE4 - Within-text compare only inside checked text.
// RULE5 - No checking: all outside, airline code excepted.
// RULE6 - Zero delay, empty list: never drop sync.
// RULE7 - Outside-text characters match only outside limits.
// RULE8 - With checking, drop after block check characters.
// RULE9 - Drop delay counts from the earliest trigger.
// RULE10 - Zero delay drops right after triggering character.
// RULE11 - Frame width from code plus parity bit.
// RULE12 - Ignore parity frames bit, forces generated value.
// RULE13 - Acquire on two syncs, one in monosync.
// RULE14 - Nine-bit frames compare only last sixteen bits.
// RULE15 - Text starts after start, includes stop character.
// RULE16 - After drop, stop storing and hunt bitwise.
// RULE17 - Count characters after trigger up to delay.
module char_sync_drop_framer (
  input  wire logic                                                 core_clk,
  input  wire logic                                                 rst,
  input  wire logic                                                 clk_en,
  input  wire logic                                                 rx_bit_valid,
  input  wire logic                                                 rx_bit,
  input  wire logic                                                 sync_char_mode,
  input  wire logic                                                 monosync,
  input  wire logic [1:0]                                           code_sel,
  input  wire char_sync_drop_pkg::parity_type                       parity_sel,
  input  wire logic                                                 airline_code,
  input  wire logic                                                 err_check_en,
  input  wire logic [char_sync_drop_pkg::BCC_W-1:0]                 bcc_len,
  input  wire logic [char_sync_drop_pkg::SYNC_W-1:0]                sync_pattern,
  input  wire logic [char_sync_drop_pkg::CHAR_W-1:0]                start_char,
  input  wire logic [char_sync_drop_pkg::CHAR_W-1:0]                stop_char,
  input  wire logic [char_sync_drop_pkg::DROP_N-1:0]                drop_char_en,
  input  wire logic [char_sync_drop_pkg::DROP_N-1:0][char_sync_drop_pkg::CHAR_W-1:0] drop_chars,
  input  wire logic [char_sync_drop_pkg::DELAY_W-1:0]               drop_delay,
  output logic                                                      in_sync,
  output logic                                                      char_valid,
  output logic [char_sync_drop_pkg::CHAR_W-1:0]                     char_data,
  output logic                                                      char_in_text,
  output logic                                                      char_idle,
  output logic                                                      parity_err,
  output logic                                                      drop_sync
);
  import char_sync_drop_pkg::*;

  // Registered state of the framer.
  state_type                 state_reg;
  logic [SYNC_W-1:0]         hunt_reg;
  logic [CHAR_W-1:0]         shift_reg;
  logic [CNT_W-1:0]          bit_cnt_reg;
  logic                      in_text_reg;
  logic                      bcc_active_reg;
  logic [BCC_W-1:0]          bcc_left_reg;
  logic                      pending_reg;
  logic [DELAY_W-1:0]        delay_cnt_reg;
  logic                      char_valid_reg;
  logic [CHAR_W-1:0]         char_data_reg;
  logic                      char_in_text_reg;
  logic                      char_idle_reg;
  logic                      parity_err_reg;
  logic                      drop_sync_reg;

  // Decode of the current bit, character and drop decision.
  logic [CNT_W-1:0]          data_bits;
  logic [CNT_W-1:0]          frame_w;
  logic [4:0]                cmp_len;
  logic [SYNC_W:0]           mask_wide;
  logic [SYNC_W-1:0]         hunt_next;
  logic                      sync_hit;
  logic                      bit_step;
  logic                      char_done;
  logic [CHAR_W-1:0]         raw_char;
  logic [CHAR_W-1:0]         frame_mask;
  logic [CHAR_W-1:0]         data_mask;
  logic                      data_xor;
  logic                      fixed_par;
  logic [CHAR_W-1:0]         rx_char;
  logic                      par_bad;
  logic [DROP_N-1:0]         list_hit;
  logic                      start_hit;
  logic                      stop_hit;
  logic                      within_ok;
  logic                      outside_ok;
  logic                      bcc_end;
  logic                      trigger;
  logic                      drop_allowed;
  logic [DELAY_W-1:0]        delay_inc;
  logic                      drop_now;

  // Frame width follows the data code, plus one bit for any parity mode.
  // Ignore mode still spends a bit on the line, so it widens the frame like even or odd.
  always_comb begin
    data_bits = BASE_DATA_BITS + {2'h0, code_sel}; // RULE11
    frame_w   = data_bits + {3'h0, parity_sel != PAR_NONE}; // RULE11 RULE12
  end

  // The sync window spans one or two frames; two nine-bit frames keep only sixteen bits.
  // The window is a mask over the low bits of the shifter, so a shorter frame ignores
  // older history. The pattern must hold the newest bit in its lowest position.
  // A zero-filled shifter after reset can fake a match, since its zero bits are compared like received ones.
  always_comb begin
    if (monosync) begin
      cmp_len = {1'b0, frame_w}; // RULE13
    end else if ({frame_w, 1'b0} > SYNC_CMP_MAX) begin
      cmp_len = SYNC_CMP_MAX; // RULE14
    end else begin
      cmp_len = {frame_w, 1'b0}; // RULE13
    end
    mask_wide = (17'h00001 << cmp_len) - 17'h00001;
    hunt_next = {hunt_reg[SYNC_W-2:0], rx_bit};
    sync_hit  = ((hunt_next ^ sync_pattern) & mask_wide[SYNC_W-1:0]) == 16'h0000;
  end

  // Character assembly and parity handling on the final bit of a frame.
  // The frame is right-justified by shifting away the unused low bits of the assembler.
  // Parity is judged on the raw frame, before any forced bit replaces the received one.
  always_comb begin
    bit_step   = clk_en && rx_bit_valid;
    char_done  = bit_step && (state_reg == FRAMED) && (bit_cnt_reg == frame_w - ONE_CNT);
    raw_char   = {rx_bit, shift_reg[CHAR_W-1:1]} >> (CHAR_W_CNT - frame_w);
    frame_mask = IDLE_CHAR >> (CHAR_W_CNT - frame_w);
    data_mask  = IDLE_CHAR >> (CHAR_W_CNT - data_bits);
    data_xor   = ^(raw_char & data_mask);
    // Short codes generate a zero bit, eight-bit codes generate odd parity.
    fixed_par  = (data_bits == FULL_CODE_BITS) ? ~data_xor : 1'b0; // RULE12
    if (parity_sel == PAR_IGNORE) begin
      rx_char = (raw_char & data_mask) | ({8'h00, fixed_par} << data_bits); // RULE12
    end else begin
      rx_char = raw_char;
    end
    unique case (parity_sel)
      PAR_EVEN: par_bad = data_xor ^ raw_char[data_bits];
      PAR_ODD:  par_bad = ~(data_xor ^ raw_char[data_bits]);
      PAR_NONE, PAR_IGNORE: par_bad = 1'b0;
    endcase
  end

  // One comparator per entry of the drop list.
  // Entries are compared with the stored form of the character, forced parity included.
  genvar gi;
  generate
    for (gi = 0; gi < DROP_N; gi++) begin : g_match
      assign list_hit[gi] = drop_char_en[gi] && (rx_char == drop_chars[gi]); // RULE3
    end
  endgenerate

  // Trigger selection: which entries may match depends on the checked-text limits.
  // Entry zero looks only inside text, or anywhere with airline code and no checking, and the other six only outside it, so one value in
  // both places still drops sync outside text. The block check end is a trigger of its
  // own, which keeps a frame with no match from holding the framer forever.
  always_comb begin
    start_hit  = err_check_en && !in_text_reg && !bcc_active_reg && (rx_char == start_char);
    stop_hit   = err_check_en && in_text_reg && (rx_char == stop_char); // RULE15
    within_ok  = (err_check_en && in_text_reg) || (!err_check_en && airline_code); // RULE4 RULE5
    outside_ok = !(err_check_en && in_text_reg); // RULE5 RULE7
    bcc_end    = (stop_hit && (bcc_len == 2'h0)) ||
                 (err_check_en && bcc_active_reg && (bcc_left_reg == BCC_ONE)); // RULE8
    trigger    = (within_ok && list_hit[WITHIN_IDX]) ||
                 (outside_ok && (|list_hit[DROP_N-1:1])) || bcc_end; // RULE7 RULE9
    // An empty list with zero delay, or async operation, never loses sync.
    // That also silences the block check end, so a capture of raw line data runs unbroken.
    drop_allowed = sync_char_mode && !((drop_delay == 4'h0) && (drop_char_en == 7'h00)); // RULE2 RULE6
    delay_inc  = delay_cnt_reg + 4'h1;
    if (!char_done || !drop_allowed) begin
      drop_now = 1'b0;
    end else if (pending_reg) begin
      drop_now = (delay_inc == drop_delay); // RULE17
    end else begin
      drop_now = trigger && (drop_delay == 4'h0); // RULE10
    end
  end

  // Hunt and framing state; the hunt shifter is cleared on drop so stale bits cannot resync.
  // The framer commits to a frame boundary on the first window match and does not look
  // for sync again until it drops, so a false match shows up as garbled characters.
  // That is why a monosync pattern must never occur inside the data stream.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_reg   <= HUNT;
      hunt_reg    <= '0;
      bit_cnt_reg <= '0;
    end else if (bit_step) begin
      unique case (state_reg)
        HUNT: begin
          hunt_reg <= hunt_next; // RULE16
          if (sync_hit) begin
            state_reg   <= FRAMED; // RULE13
            bit_cnt_reg <= '0;
          end
        end
        FRAMED: begin
          if (drop_now) begin
            state_reg <= HUNT; // RULE16
            hunt_reg  <= '0;
          end
          if (char_done) begin
            bit_cnt_reg <= '0;
          end else begin
            bit_cnt_reg <= bit_cnt_reg + ONE_CNT;
          end
        end
      endcase
    end
  end

  // Bits enter least significant first, so the assembler shifts right.
  // Its contents only matter on the final bit of a frame, so only reset clears it.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      shift_reg <= '0;
    end else if (bit_step && (state_reg == FRAMED)) begin
      shift_reg <= {rx_bit, shift_reg[CHAR_W-1:1]}; // RULE11
    end
  end

  // Checked-text region and the block check characters after the stop delimiter.
  // A start delimiter is ignored while block check characters are counted, since those
  // characters are check values and may take any pattern.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      in_text_reg    <= 1'b0;
      bcc_active_reg <= 1'b0;
      bcc_left_reg   <= '0;
    end else if (clk_en) begin
      if (drop_now || (state_reg == HUNT)) begin
        in_text_reg    <= 1'b0;
        bcc_active_reg <= 1'b0;
        bcc_left_reg   <= '0;
      end else if (char_done) begin
        if (start_hit) begin
          in_text_reg <= 1'b1; // RULE15
        end else if (stop_hit) begin
          in_text_reg    <= 1'b0; // RULE15
          bcc_active_reg <= bcc_len != 2'h0;
          bcc_left_reg   <= bcc_len;
        end else if (bcc_active_reg) begin
          bcc_left_reg   <= bcc_left_reg - BCC_ONE; // RULE8
          bcc_active_reg <= bcc_left_reg != BCC_ONE;
        end
      end
    end
  end

  // Only the earliest trigger arms the counter; later ones are ignored while it runs.
  // The count advances on each stored character after the trigger, so a delay of N
  // drops on the Nth character that follows it. A configuration change that forbids
  // dropping disarms the counter at once.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pending_reg   <= 1'b0;
      delay_cnt_reg <= '0;
    end else if (clk_en) begin
      if (drop_now || (state_reg == HUNT) || !drop_allowed) begin
        pending_reg   <= 1'b0;
        delay_cnt_reg <= '0;
      end else if (char_done) begin
        if (pending_reg) begin
          delay_cnt_reg <= delay_inc; // RULE17
        end else if (trigger) begin
          pending_reg   <= 1'b1; // RULE9
          delay_cnt_reg <= '0;
        end
      end
    end
  end

  // Stored characters and the drop pulse; the triggering or last counted character is still stored.
  // A low clock enable holds both pulses, so a consumer must qualify them with the enable.
  // The text flag is taken before the stop delimiter closes the region, so it covers it.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      char_valid_reg   <= 1'b0;
      char_data_reg    <= '0;
      char_in_text_reg <= 1'b0;
      char_idle_reg    <= 1'b0;
      parity_err_reg   <= 1'b0;
      drop_sync_reg    <= 1'b0;
    end else if (clk_en) begin
      char_valid_reg <= char_done; // RULE6
      drop_sync_reg  <= drop_now; // RULE10
      if (char_done) begin
        char_data_reg    <= rx_char;
        char_in_text_reg <= err_check_en && in_text_reg;
        char_idle_reg    <= rx_char == frame_mask; // RULE1
        parity_err_reg   <= par_bad;
      end
    end
  end

  // Outputs come straight from registers; in_sync is the framing state itself.
  assign in_sync      = state_reg == FRAMED;
  assign char_valid   = char_valid_reg;
  assign char_data    = char_data_reg;
  assign char_in_text = char_in_text_reg;
  assign char_idle    = char_idle_reg;
  assign parity_err   = parity_err_reg;
  assign drop_sync    = drop_sync_reg;

endmodule // char_sync_drop_framer

// [char_sync_drop_pkg.sv]
package char_sync_drop_pkg;

  // Character and sync comparator geometry.
  localparam int CHAR_W  = 9;
  localparam int SYNC_W  = 16;
  localparam int DROP_N  = 7;
  localparam int DELAY_W = 4;
  localparam int CNT_W   = 4;
  localparam int BCC_W   = 2;

  // Entry zero of the drop list is the within-text character.
  localparam int WITHIN_IDX = 0;

  // The smallest data code has five bits; the code select adds to it.
  localparam logic [CNT_W-1:0] BASE_DATA_BITS = 4'h5;
  localparam logic [CNT_W-1:0] FULL_CODE_BITS = 4'h8;
  localparam logic [CNT_W-1:0] CHAR_W_CNT     = 4'h9;
  localparam logic [CNT_W-1:0] ONE_CNT        = 4'h1;

  // Longest sync comparison window, in bits.
  localparam logic [4:0] SYNC_CMP_MAX = 5'h10;

  // Block check length of a 16-bit CRC, in characters.
  localparam logic [BCC_W-1:0] BCC_CRC16_CHARS = 2'h2;
  localparam logic [BCC_W-1:0] BCC_ONE         = 2'h1;

  // The line idle character is all ones at the frame width.
  localparam logic [CHAR_W-1:0] IDLE_CHAR = 9'h1FF;

  typedef enum logic [1:0] {
    PAR_NONE   = 2'h0,
    PAR_EVEN   = 2'h1,
    PAR_ODD    = 2'h2,
    PAR_IGNORE = 2'h3
  } parity_type;

  typedef enum logic [1:0] {
    HUNT   = 2'b01,
    FRAMED = 2'b10
  } state_type;

endpackage

// [char_sync_drop_asserts.sv]
`timescale 1ns/100ps
// Port-level checks on framing and drop-sync behaviour.
module char_sync_drop_asserts
  import char_sync_drop_pkg::*;
(
  input wire logic              core_clk,
  input wire logic              rst,
  input wire logic              clk_en,
  input wire logic              rx_bit_valid,
  input wire logic              sync_char_mode,
  input wire logic [1:0]        code_sel,
  input wire parity_type        parity_sel,
  input wire logic [DROP_N-1:0] drop_char_en,
  input wire logic [DELAY_W-1:0] drop_delay,
  input wire logic              in_sync,
  input wire logic              char_valid,
  input wire logic [CHAR_W-1:0] char_data,
  input wire logic              char_idle,
  input wire logic              parity_err,
  input wire logic              drop_sync
);
  logic [3:0] fw;
  logic [8:0] ones;

  // Frame width and its all-ones value follow the live code and parity selection.
  assign fw   = 4'h5 + 4'(code_sel) + 4'(parity_sel != PAR_NONE);
  assign ones = 9'((10'h001 << fw) - 10'h001);

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_drop_on_char: assert property (drop_sync |-> char_valid)
    else $error("drop pulse without a stored character");
  a_drop_ends_sync: assert property (drop_sync |-> !in_sync)
    else $error("sync held through a drop");
  a_char_needs_sync: assert property (char_valid && $past(clk_en) |-> $past(in_sync))
    else $error("character stored while hunting");
  a_async_no_drop: assert property (!sync_char_mode |-> !drop_sync)
    else $error("drop outside synchronous character mode");
  a_keep_all: assert property (drop_delay == 4'h0 && drop_char_en == 7'h00 |-> !drop_sync)
    else $error("drop with empty list and zero delay");
  a_idle_flag: assert property (char_valid |-> char_idle == (char_data == ones))
    else $error("idle flag disagrees with data");
  a_ignore_zero: assert property (char_valid && parity_sel == PAR_IGNORE && code_sel != 2'h3
    |-> char_data[4'h5 + 4'(code_sel)] == 1'b0 && !parity_err)
    else $error("ignored parity bit not forced low");
  a_width_fits: assert property (char_valid |-> (char_data >> fw) == 9'h000)
    else $error("stored character wider than frame");
  a_sync_on_bit: assert property ($rose(in_sync) |-> $past(rx_bit_valid && clk_en))
    else $error("sync gained without a taken bit");
endmodule // char_sync_drop_asserts

// [line_src.sv]
`timescale 1ns/100ps
// Far end of the line: frames go out LSB first, one bit per taken strobe.
module line_src (
  input  wire logic core_clk,
  output logic      clk_en,
  output logic      rx_bit_valid,
  output logic      rx_bit
);
  // The line sits still with no strobe until the first frame.
  initial begin
    clk_en       = 1'b1;
    rx_bit_valid = 1'b0;
    rx_bit       = 1'b0;
  end

  // A stall keeps the strobe up with the enable low, so a frozen framer must not take it.
  task automatic send(input logic [8:0] c, input int n);
    for (int i = 0; i < n; i++) begin
      rx_bit_valid = 1'b1;
      rx_bit       = c[i];
      clk_en       = ($urandom % 5) != 0;
      if (!clk_en) begin
        @(posedge core_clk);
        #1 clk_en = 1'b1;
      end
      @(posedge core_clk);
      #1;
    end
  endtask

  // A released line shows the inverse of its last bit, so stale data cannot pass for a match.
  task automatic idle();
    rx_bit_valid = 1'b0;
    rx_bit       = ~rx_bit;
  endtask
endmodule // line_src

// [tb.sv]
`timescale 1ns/100ps
// Self-checking bench with a reference model of framing and drop-sync.
module tb;
  import char_sync_drop_pkg::*;
  localparam logic [8:0]  SYNC_CH  = 9'h016;
  localparam logic [8:0]  POOL [7] = '{9'h002, 9'h003, 9'h0BB, 9'h0A4, 9'h041, 9'h0FF, 9'h05D};
  localparam logic [15:0] CFG [6]  = '{16'hD7F1, 16'hC7F0, 16'h97E2, 16'hB010, 16'h57F0, 16'hD813};
  logic                          core_clk, rst, clk_en, rx_bit_valid, rx_bit, monosync, airline_code;
  logic                          sync_char_mode, err_check_en, in_sync, char_valid, char_in_text;
  logic                          char_idle, parity_err, drop_sync;
  logic [1:0]                    code_sel, bcc_len;
  parity_type                    parity_sel;
  logic [SYNC_W-1:0]             sync_pattern;
  logic [CHAR_W-1:0]             start_char, stop_char, char_data;
  logic [DROP_N-1:0]             drop_char_en;
  logic [DROP_N-1:0][CHAR_W-1:0] drop_chars;
  logic [DELAY_W-1:0]            drop_delay;
  logic [12:0]                   expq [$];
  int                            n_errors, checked, cycles, intext, bccn, armed, cnt;

  char_sync_drop_framer char_sync_drop_framer_i (.core_clk(core_clk), .rst(rst), .clk_en(clk_en),
    .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit), .sync_char_mode(sync_char_mode), .monosync(monosync),
    .code_sel(code_sel), .parity_sel(parity_sel), .airline_code(airline_code), .err_check_en(err_check_en),
    .bcc_len(bcc_len), .sync_pattern(sync_pattern), .start_char(start_char), .stop_char(stop_char),
    .drop_char_en(drop_char_en), .drop_chars(drop_chars), .drop_delay(drop_delay), .in_sync(in_sync),
    .char_valid(char_valid), .char_data(char_data), .char_in_text(char_in_text), .char_idle(char_idle),
    .parity_err(parity_err), .drop_sync(drop_sync));
  line_src line_src_i (.core_clk(core_clk), .clk_en(clk_en), .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit));

  // Free-running clock; the ceiling sits far above the few thousand cycles the tests need.
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 40000) begin
      n_errors++;
      end_sim();
    end
  end

  task automatic check(input logic [12:0] exp, input logic [12:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  task automatic end_sim();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Every stored character must have been predicted, in order; an unexpected one is a mismatch.
  // A frozen framer holds its pulse, so only an enabled edge counts it.
  always @(posedge core_clk) begin
    if (char_valid === 1'b1 && clk_en === 1'b1) begin
      if (expq.size() > 0) check(expq.pop_front(), {drop_sync, parity_err, char_idle, char_in_text, char_data});
      else check(13'h0000, 13'h1FFF);
    end
  end

  // Text region and drop countdown for one stored character; returns drop and in-text.
  function automatic logic [1:0] model(input logic [8:0] c);
    logic t, it, dr;
    t  = 1'b0;
    it = 1'b0;
    dr = 1'b0;
    if (bccn > 0) begin
      bccn--;
      t = (bccn == 0);
    end else if (intext != 0) begin
      it = 1'b1;
      if (c == stop_char) begin
        intext = 0;
        bccn   = bcc_len;
        t      = (bcc_len == 2'h0);
      end
    end else if (err_check_en && c == start_char) intext = 1;
    t = t | ((err_check_en ? it : airline_code) && drop_char_en[0] && c == drop_chars[0]);
    for (int i = 1; i < DROP_N; i++) t = t | (!(err_check_en && it) && drop_char_en[i] && c == drop_chars[i]);
    t = t && sync_char_mode && (drop_delay != 4'h0 || drop_char_en != 7'h00);
    if (armed != 0) begin
      cnt++;
      dr = (cnt == drop_delay);
    end else if (t) begin
      armed = 1;
      cnt   = 0;
      dr    = (drop_delay == 4'h0);
    end
    return {dr, it};
  endfunction

  // One test: reset, acquire sync, then a random stream; after a drop nothing more is stored.
  task automatic run(input int n, input bit alpha);
    int         nd, fw, ns, len;
    logic [8:0] c, e, ones;
    logic [1:0] m;
    logic       pe;
    bit         dn;
    nd     = 5 + code_sel;
    fw     = nd + (parity_sel != PAR_NONE);
    ones   = 9'((1 << fw) - 1);
    ns     = monosync ? 1 : 2;
    len    = (ns * fw > 16) ? 16 : ns * fw;
    dn     = 1'b0;
    intext = 0;
    bccn   = 0;
    armed  = 0;
    for (int k = 0; k < 16; k++) sync_pattern[k] = (k < len) ? SYNC_CH[(ns * fw - 1 - k) % fw] : 1'b0;
    rst = 1'b1;
    repeat (2) @(posedge core_clk);
    #1 rst = 1'b0;
    repeat (ns) line_src_i.send(SYNC_CH, fw);
    for (int i = 0; i < n && !dn; i++) begin
      c = alpha ? POOL[$urandom % 7] : (($urandom % 3 == 0) ? 9'h1FF : 9'($urandom));
      c = c & ones;
      e = c;
      if (parity_sel == PAR_IGNORE) e[nd] = (nd == 8) ? ~^c[7:0] : 1'b0;
      pe = (parity_sel == PAR_EVEN) ? ^c : ((parity_sel == PAR_ODD) ? ~^c : 1'b0);
      m  = model(e);
      dn = m[1];
      expq.push_back({m[1], pe, e == ones, m[0], e});
      line_src_i.send(c, fw);
    end
    if (dn) repeat (2) line_src_i.send(9'h1FF, fw);
    line_src_i.idle();
    repeat (4) @(posedge core_clk);
    #1;
    check(13'(!dn), 13'(in_sync));
    check(13'h0000, 13'(expq.size()));
    $display("test done n_errors=%0d", n_errors);
  endtask

  // Frame widths and parity modes first, then drop configurations from the table.
  initial begin
    rst            = 1'b1;
    sync_char_mode = 1'b1;
    monosync       = 1'b0;
    code_sel       = 2'h3;
    parity_sel     = PAR_NONE;
    airline_code   = 1'b0;
    err_check_en   = 1'b0;
    bcc_len        = 2'h2;
    sync_pattern   = 16'h0000;
    start_char     = 9'h002;
    stop_char      = 9'h003;
    drop_char_en   = 7'h00;
    drop_chars     = {9'h011, 9'h07E, 9'h05D, 9'h0BB, 9'h0B3, 9'h0A4, 9'h0BB};
    drop_delay     = 4'h0;
    void'($urandom(23));
    for (int k = 0; k < 16; k++) begin
      code_sel   = 2'(k / 4);
      parity_sel = parity_type'(k % 4);
      monosync   = k[0];
      run(6, 1'b0);
    end
    code_sel   = 2'h3;
    parity_sel = PAR_NONE;
    monosync   = 1'b0;
    for (int k = 0; k < 18; k++) begin
      {sync_char_mode, err_check_en, airline_code, bcc_len, drop_char_en, drop_delay} = CFG[k % 6];
      run(14, 1'b1);
    end
    end_sim();
  end
endmodule // tb

bind char_sync_drop_framer char_sync_drop_asserts char_sync_drop_asserts_i (.core_clk(core_clk), .rst(rst),
  .clk_en(clk_en), .rx_bit_valid(rx_bit_valid), .sync_char_mode(sync_char_mode), .code_sel(code_sel),
  .parity_sel(parity_sel), .drop_char_en(drop_char_en), .drop_delay(drop_delay), .in_sync(in_sync),
  .char_valid(char_valid), .char_data(char_data), .char_idle(char_idle), .parity_err(parity_err),
  .drop_sync(drop_sync));
